// File: bench/cbc_link_sva.sv
`timescale 1ns/10ps
module cbc_link_sva (
	input wire logic               ref_clk,   // clock
	input wire logic               rst_b,     // async reset, low
	input wire logic               frm_valid, // frame present
	input wire logic               frm_rw,    // 1 write, 0 read/command
	input wire logic [2:0]         frm_page,  // page field
	input wire logic [5:0]         frm_addr,  // address field
	input wire cbc_pkg::cbc_word_t frm_data,  // data field
	input wire logic [3:0]         frm_dev,   // chain address field
	input wire logic [3:0]         frm_crc,   // check field
	input wire logic               rsp_valid, // read answer present
	input wire cbc_pkg::cbc_word_t rsp_data   // read answer
);
	import cbc_pkg::*;
	cbc_word_t  setup_r;
	cbc_word_t  time_r;
	cbc_cells_t slot_r [16];
	wire logic  wr2 = frm_valid && frm_rw && frm_page == 3'b010;
	wire logic  rd2 = frm_valid && !frm_rw && frm_page == 3'b010;
	wire logic  cmd = frm_valid && !frm_rw && frm_page == 3'b011;
	// ==========================================================
	// Shadow copies of what the device must answer on a read.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			setup_r <= 14'h0000;
		end else if (wr2 && frm_addr == 6'h13) begin
			setup_r <= frm_data;
		end else if (cmd && frm_addr == 6'h10) begin
			setup_r[9] <= 1'b1;
		end else if (cmd && frm_addr == 6'h11) begin
			setup_r[9] <= 1'b0;
		end
	end
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			time_r <= 14'h0000;
		end else if (wr2 && frm_addr == 6'h15) begin
			time_r <= frm_data;
		end
	end
	// Slot writes follow the pointer held in the setup shadow.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < 16; i++) begin
				slot_r[i] <= 12'h000;
			end
		end else if (wr2 && frm_addr == 6'h14) begin
			slot_r[setup_r[8:5]] <= frm_data[11:0];
		end
	end
	// ==========================================================
	// Link properties.
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	rsp_cause_a: assert property (rsp_valid |-> $past(rd2))
		else $error("answer without a read frame");
	rsp_due_a: assert property (rd2 |=> rsp_valid)
		else $error("read frame not answered next cycle");
	cmd_quiet_a: assert property (cmd |=> !rsp_valid [*2])
		else $error("command frame was answered");
	cmd_zero_a: assert property (frm_valid && !frm_rw
		|-> frm_data == 14'h0000)
		else $error("non-write frame carries data");
	frm_hold_a: assert property (!frm_valid |-> $stable({frm_rw, frm_page,
		frm_addr, frm_data, frm_dev, frm_crc}))
		else $error("frame fields moved between frames");
	rsp_hold_a: assert property (!rsp_valid |-> $stable(rsp_data))
		else $error("answer data moved without a read");
	setup_back_a: assert property (rsp_valid && frm_addr == 6'h13
		|-> rsp_data == setup_r)
		else $error("setup readback differs");
	slot_back_a: assert property (rsp_valid && frm_addr == 6'h14
		|-> rsp_data[11:0] == slot_r[setup_r[8:5]])
		else $error("pattern readback differs");
	time_back_a: assert property (rsp_valid && frm_addr == 6'h15
		|-> rsp_data == time_r)
		else $error("time readback differs");
	cover property (rd2 ##1 rsp_valid);
	cover property (cmd && frm_addr == 6'h10);
	cover property (cmd && frm_addr == 6'h11);
	cover property (wr2 && frm_addr == 6'h14);
endmodule : cbc_link_sva

// File: bench/test_cell_balance_controller.sv
`timescale 1ns/10ps
`include "cbc_regs.svh"
module test_cell_balance_controller;
	import cbc_pkg::*;
	logic        ref_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [3:0]  sw_addr = 4'h0;
	logic [15:0] sw_wdata = 16'h0000;
	logic        sw_wr = 1'b0;
	logic        sw_rd = 1'b0;
	logic [15:0] sw_rdata;
	logic        measure_busy = 1'b0;
	logic        chain_en = 1'b0;
	logic        chain_b = 1'b1;
	logic [3:0]  dev_addr = 4'h5;
	logic        chk_sw = 1'b0;
	logic        rd_d = 1'b0;
	cbc_cells_t  bal_sw;
	cbc_cells_t  pat;
	int          miscompares = 0;
	int          n_compared = 0;
	int          rsp_b = 0;
	logic [15:0] exp_rd [$];
	cbc_cells_t  exp_sw [$];
	cbc_cells_t  aexp [7] = '{12'h249, 12'h000, 12'h924, 12'h492, 12'h000,
		12'h249, 12'h248};
	int          dly [7] = '{120, 136, 136, 272, 136, 36, 114};
	cbc_cells_t  apat [4] = '{12'h249, 12'h924, 12'h492, 12'h000};

	always #5 ref_clk = ~ref_clk;
	cbc_link_if i_cbc_link_if ();
	cbc_link_if i_cbc_link_if_b ();
	cbc_host i_cbc_host (.ref_clk(ref_clk), .rst_b(rst_b),
		.link(i_cbc_link_if.host), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
		.sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
	cbc_device #(.TICK_CYCLES(4)) i_cbc_device (.ref_clk(ref_clk),
		.rst_b(rst_b), .link(i_cbc_link_if.dev), .chain_en(chain_en),
		.my_dev_addr(dev_addr), .measure_busy(measure_busy), .bal_sw(bal_sw));
	// The second device hears only the bench, which breaks framing on purpose.
	cbc_device #(.TICK_CYCLES(4)) i_cbc_device_b (.ref_clk(ref_clk),
		.rst_b(rst_b), .link(i_cbc_link_if_b.dev), .chain_en(chain_b),
		.my_dev_addr(dev_addr), .measure_busy(measure_busy), .bal_sw());
	cbc_link_sva i_cbc_link_sva (.ref_clk(ref_clk), .rst_b(rst_b),
		.frm_valid(i_cbc_link_if.frm_valid), .frm_rw(i_cbc_link_if.frm_rw),
		.frm_page(i_cbc_link_if.frm_page), .frm_addr(i_cbc_link_if.frm_addr),
		.frm_data(i_cbc_link_if.frm_data), .frm_dev(i_cbc_link_if.frm_dev),
		.frm_crc(i_cbc_link_if.frm_crc), .rsp_valid(i_cbc_link_if.rsp_valid),
		.rsp_data(i_cbc_link_if.rsp_data));

	// ==========================================================
	// Checking.
	task automatic cmp(input logic [15:0] got, input logic [15:0] e);
		n_compared++;
		if (got !== e) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, got, e);
		end
	endtask : cmp
	always @(posedge ref_clk) begin
		rd_d <= sw_rd;
		if (rd_d) begin
			cmp(sw_rdata, exp_rd.pop_front());
		end
		if (chk_sw) begin
			cmp({4'h0, bal_sw}, {4'h0, exp_sw.pop_front()});
		end
		if (i_cbc_link_if_b.rsp_valid === 1'b1) begin
			rsp_b++;
		end
	end
	task automatic complete_run();
		$display("counts: %0d compared, %0d unexpected", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : complete_run

	// ==========================================================
	// Drivers.
	task automatic sw_op(input logic [3:0] a, input logic [15:0] d,
		input logic r);
		@(posedge ref_clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= !r;
		sw_rd <= r;
		@(posedge ref_clk);
		sw_wr <= 1'b0;
		sw_rd <= 1'b0;
	endtask : sw_op
	task automatic frame(input logic rw, input logic [2:0] pg,
		input logic [5:0] ad, input logic [13:0] d);
		sw_op(`CBC_H_CMD, {2'b00, 4'h5, rw, pg, ad}, 1'b0);
		sw_op(`CBC_H_WDATA, {2'b00, d}, 1'b0);
		sw_op(`CBC_H_GO, 16'h0000, 1'b0);
		repeat (4) @(posedge ref_clk);
	endtask : frame
	task automatic wr(input logic [5:0] ad, input logic [13:0] d);
		frame(1'b1, 3'b010, ad, d);
	endtask : wr
	task automatic cmd(input logic [5:0] ad);
		frame(1'b0, 3'b011, ad, 14'h0000);
	endtask : cmd
	task automatic rd(input logic [5:0] ad, input logic [13:0] e);
		frame(1'b0, 3'b010, ad, 14'h0000);
		exp_rd.push_back(16'h0001);
		sw_op(`CBC_H_STATUS, 16'h0000, 1'b1);
		exp_rd.push_back({2'b00, e});
		sw_op(`CBC_H_RDATA, 16'h0000, 1'b1);
	endtask : rd
	task automatic sw_is(input cbc_cells_t e);
		exp_sw.push_back(e);
		@(posedge ref_clk);
		chk_sw <= 1'b1;
		@(posedge ref_clk);
		chk_sw <= 1'b0;
	endtask : sw_is
	// Reads the setup register of the second device with chosen framing.
	task automatic frame_b(input logic [3:0] dv, input logic [3:0] c);
		@(posedge ref_clk);
		{i_cbc_link_if_b.frm_valid, i_cbc_link_if_b.frm_rw,
			i_cbc_link_if_b.frm_page, i_cbc_link_if_b.frm_addr,
			i_cbc_link_if_b.frm_data, i_cbc_link_if_b.frm_dev,
			i_cbc_link_if_b.frm_crc} <= {1'b1, 1'b0, 3'b010, 6'h13,
			14'h0000, dv, c};
		@(posedge ref_clk);
		i_cbc_link_if_b.frm_valid <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask : frame_b

	initial begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		complete_run();
	end
	initial begin
		{i_cbc_link_if_b.frm_valid, i_cbc_link_if_b.frm_rw,
			i_cbc_link_if_b.frm_page, i_cbc_link_if_b.frm_addr,
			i_cbc_link_if_b.frm_data, i_cbc_link_if_b.frm_dev,
			i_cbc_link_if_b.frm_crc} = 33'h0_0000_0000;
		void'($urandom(32'h121c1d91));
		repeat (5) @(posedge ref_clk);
		rst_b <= 1'b1;
		rd(6'h13, 14'h0000);
		rd(6'h15, 14'h0000);
		exp_rd.push_back(16'h1495);
		sw_op(`CBC_H_CMD, 16'h0000, 1'b1);
		sw_is(12'h000);
		sw_op(4'hf, 16'hffff, 1'b0);
		exp_rd.push_back(16'h0000);
		sw_op(4'hf, 16'h0000, 1'b1);
		$display("reset test done");
		pat = cbc_cells_t'($urandom) | 12'h001;
		wr(6'h13, 14'h0001);
		wr(6'h14, {2'b00, pat});
		cmd(6'h10);
		exp_rd.push_back(16'h0000);
		sw_op(`CBC_H_STATUS, 16'h0000, 1'b1);
		sw_is(pat);
		rd(6'h14, {2'b00, pat});
		// Busy alone must not stop the switches until pause is armed.
		measure_busy <= 1'b1;
		repeat (3) @(posedge ref_clk);
		sw_is(pat);
		wr(6'h19, 14'h0080);
		sw_is(12'h000);
		measure_busy <= 1'b0;
		repeat (3) @(posedge ref_clk);
		sw_is(pat);
		cmd(6'h11);
		sw_is(12'h000);
		rd(6'h13, 14'h0001);
		wr(6'h13, 14'h0201);
		sw_is(pat);
		wr(6'h13, 14'h0001);
		sw_is(12'h000);
		wr(6'h13, 14'h0200);
		sw_is(12'h000);
		$display("manual test done");
		for (int k = 0; k < 2; k++) begin
			logic [6:0] c;
			c = (k == 0) ? 7'h03 : 7'h0f;
			pat = cbc_cells_t'($urandom) | 12'h800;
			wr(6'h13, 14'h0002);
			wr(6'h14, {2'b00, pat});
			wr(6'h15, {c, 7'h7f});
			rd(6'h15, {c, 7'h7f});
			cmd(6'h10);
			repeat (c * 80 - 20) @(posedge ref_clk);
			sw_is(pat);
			repeat (40) @(posedge ref_clk);
			sw_is(12'h000);
			wr(6'h13, 14'h0000);
		end
		$display("timed test done");
		for (int k = 0; k < 12; k++) begin
			wr(6'h20 + 6'(2 * k), k == 0 ? 14'h0046 :
				(k == 1 ? 14'h0000 : 14'h3fff));
			wr(6'h21 + 6'(2 * k), k == 1 ? 14'h0001 : 14'h0000);
		end
		for (int s = 1; s < 5; s++) begin
			wr(6'h13, 14'(s << 5) | 14'h0013);
			wr(6'h14, {2'b00, apat[s - 1]});
		end
		wr(6'h15, {7'h03, 7'h7f});
		cmd(6'h10);
		for (int i = 0; i < 7; i++) begin
			repeat (dly[i] - 2) @(posedge ref_clk);
			sw_is(aexp[i]);
		end
		wr(6'h13, 14'h0000);
		$display("auto test done");
		chain_en <= 1'b1;
		rd(6'h13, 14'h0000);
		chain_en <= 1'b0;
		frame_b(4'h5, 4'hf);
		frame_b(4'h5, 4'he);
		frame_b(4'h6, 4'hc);
		cmp(16'(rsp_b), 16'h0001);
		chain_b <= 1'b0;
		frame_b(4'h6, 4'h0);
		cmp(16'(rsp_b), 16'h0002);
		$display("chain test done");
		complete_run();
	end
endmodule : test_cell_balance_controller

// File: src/cbc_device.sv
`timescale 1ns/10ps
`include "cbc_regs.svh"
module cbc_device #(
	parameter int TICK_CYCLES = `CBC_CLK_HZ // clocks per second
) (
	input  wire logic           ref_clk,      // 100 MHz clock
	input  wire logic           rst_b,        // async reset, low
	cbc_link_if.dev             link,         // frames from host
	input  wire logic           chain_en,     // daisy-chain framing
	input  wire logic [3:0]     my_dev_addr,  // own chain address
	input  wire logic           measure_busy, // cell scan running
	output cbc_pkg::cbc_cells_t bal_sw        // balance switches
);
	import cbc_pkg::*;

	// ==========================================================
	// Frame acceptance
	logic       frm_ok;
	logic       wr_reg;
	logic       rd_reg;
	logic       cmd_en;
	logic       cmd_inh;
	logic [3:0] crc_calc;

	// (RULE20) chained address and CRC
	always_comb begin
		crc_calc = cbc_crc4(link.frm_dev, link.frm_rw, link.frm_page,
			link.frm_addr, link.frm_data);
		frm_ok = link.frm_valid && (!chain_en ||
			(link.frm_dev == my_dev_addr && link.frm_crc == crc_calc));
		wr_reg = frm_ok && link.frm_rw == `CBC_RW_WRITE &&
			link.frm_page == `CBC_PAGE_REG;
		rd_reg = frm_ok && link.frm_rw == `CBC_RW_CMD &&
			link.frm_page == `CBC_PAGE_REG;
		// (RULE5) enable command
		cmd_en = frm_ok && link.frm_rw == `CBC_RW_CMD &&
			link.frm_page == `CBC_PAGE_CMD &&
			link.frm_addr == `CBC_CMD_ENABLE;
		// (RULE6) inhibit command
		cmd_inh = frm_ok && link.frm_rw == `CBC_RW_CMD &&
			link.frm_page == `CBC_PAGE_CMD &&
			link.frm_addr == `CBC_CMD_INHIBIT;
	end

	// ==========================================================
	// Registers
	cbc_word_t  setup_r;
	cbc_word_t  time_r;
	cbc_word_t  devset_r;
	cbc_cells_t pat_r [16];
	logic [27:0] val_r [12];
	cbc_mode_t  mode;
	logic [3:0] ptr;
	logic [2:0] wait_code;
	logic [6:0] dur_code;
	logic       balancing_on;
	logic       pause;
	logic       dec_now;
	cbc_cells_t sw_nxt;
	logic [4:0] vidx;

	assign mode      = cbc_mode_t'(setup_r[`CBC_MODE_MSB:`CBC_MODE_LSB]);
	assign wait_code = setup_r[`CBC_WAIT_MSB:`CBC_WAIT_LSB];
	assign ptr       = setup_r[`CBC_PTR_MSB:`CBC_PTR_LSB];
	assign balancing_on       = setup_r[`CBC_EN_BIT];
	// (RULE11) duration field
	assign dur_code  = time_r[`CBC_DUR_MSB:`CBC_DUR_LSB];
	assign pause     = devset_r[`CBC_PAUSE_BIT];
	assign vidx      = 5'(link.frm_addr - `CBC_ADDR_VAL_LO);

	// Setup register; a plain write wins over the commands in the same cycle,
	// though both cannot arrive in one cycle on this link.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			setup_r <= `CBC_SETUP_RST;
		end else if (wr_reg && link.frm_addr == `CBC_ADDR_SETUP) begin
			// (RULE1) mode, wait, pointer, enable
			setup_r <= link.frm_data;
		end else if (cmd_en) begin
			// (RULE5) set enable bit
			setup_r[`CBC_EN_BIT] <= 1'b1;
		end else if (cmd_inh) begin
			// (RULE6) clear enable bit
			setup_r[`CBC_EN_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			time_r   <= `CBC_TIME_RST;
			devset_r <= `CBC_SETUP_RST;
		end else if (wr_reg) begin
			if (link.frm_addr == `CBC_ADDR_TIME)
				time_r <= link.frm_data;
			if (link.frm_addr == `CBC_ADDR_DEVSET)
				devset_r <= link.frm_data;
		end
	end

	// (RULE8) write targets slot chosen by pointer
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < 16; i++)
				pat_r[i] <= '0;
		end else if (wr_reg && link.frm_addr == `CBC_ADDR_PATTERN) begin
			pat_r[ptr] <= link.frm_data[11:0];
		end
	end

	// (RULE17) value pairs, low half first; a write beats the drain.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < 12; i++)
				val_r[i] <= '0;
		end else begin
			for (int i = 0; i < 12; i++) begin
				// (RULE21) drain value while cell is on
				if (dec_now && sw_nxt[i] && val_r[i] != '0)
					val_r[i] <= val_r[i] - 28'h0000001;
			end
			if (wr_reg && link.frm_addr >= `CBC_ADDR_VAL_LO &&
				link.frm_addr <= `CBC_ADDR_VAL_HI) begin
				if (vidx[0])
					val_r[vidx[4:1]][27:14] <= link.frm_data;
				else
					val_r[vidx[4:1]][13:0] <= link.frm_data;
			end
		end
	end

	// Read answer one cycle after the frame.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			link.rsp_valid <= 1'b0;
			link.rsp_data  <= '0;
		end else begin
			link.rsp_valid <= rd_reg;
			if (rd_reg) begin
				unique case (link.frm_addr)
					`CBC_ADDR_SETUP:   link.rsp_data <= setup_r;
					`CBC_ADDR_PATTERN: link.rsp_data <= {2'h0, pat_r[ptr]};
					`CBC_ADDR_TIME:    link.rsp_data <= time_r;
					`CBC_ADDR_DEVSET:  link.rsp_data <= devset_r;
					default: begin
						if (link.frm_addr >= `CBC_ADDR_VAL_LO &&
							link.frm_addr <= `CBC_ADDR_VAL_HI)
							link.rsp_data <= vidx[0] ?
								val_r[vidx[4:1]][27:14] :
								val_r[vidx[4:1]][13:0];
						else
							link.rsp_data <= '0;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// One-second tick; the timers count seconds to stay narrow.
	logic [31:0] pre_r;
	logic        tick;
	assign tick = (pre_r == 32'(TICK_CYCLES - 1));
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			pre_r <= '0;
		else if (tick || !balancing_on)
			pre_r <= '0;
		else
			pre_r <= pre_r + 32'h1;
	end

	// ==========================================================
	// Sequencer
	cbc_state_t  st_r;
	logic [12:0] tmr_r;
	logic [3:0]  idx_r;
	logic [3:0]  idx_inc;
	logic [12:0] dur_s;
	logic [12:0] wait_s;

	// (RULE12) 20 s per code step: 3 is 60 s, 15 is 300 s
	assign dur_s  = 13'(dur_code * `CBC_DUR_STEP_S);
	// (RULE15) code 100 gives 8 s
	assign wait_s = 13'(wait_code * `CBC_WAIT_STEP_S);
	assign idx_inc = idx_r + 4'h1;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r  <= CBC_ST_IDLE;
			tmr_r <= '0;
			idx_r <= `CBC_SLOT_FIRST;
		end else if (!balancing_on) begin
			// (RULE6) stop on cleared enable
			st_r <= CBC_ST_IDLE;
		end else begin
			unique case (st_r)
				CBC_ST_IDLE: begin
					// (RULE4) enable starts balancing
					st_r  <= CBC_ST_RUN;
					tmr_r <= dur_s;
					// (RULE9) first cycle uses slot 1
					idx_r <= `CBC_SLOT_FIRST;
				end
				CBC_ST_RUN: begin
					if (tick && mode != CBC_MODE_MANUAL) begin
						if (tmr_r > 13'h1) begin
							tmr_r <= tmr_r - 13'h1;
						end else if (mode == CBC_MODE_AUTO) begin
							// (RULE14) wait between cycles
							st_r  <= CBC_ST_WAIT;
							tmr_r <= wait_s;
						end else begin
							// (RULE2) timed mode ends
							st_r <= CBC_ST_DONE;
						end
					end
				end
				CBC_ST_WAIT: begin
					if (tick) begin
						if (tmr_r > 13'h1) begin
							tmr_r <= tmr_r - 13'h1;
						end else begin
							st_r  <= CBC_ST_RUN;
							tmr_r <= dur_s;
							// (RULE10) empty slot restarts at 1
							if (pat_r[idx_inc] == '0 ||
								idx_inc == `CBC_SLOT_MANUAL)
								idx_r <= `CBC_SLOT_FIRST;
							else
								// (RULE9) step one slot
								idx_r <= idx_inc;
						end
					end
				end
				CBC_ST_DONE: st_r <= CBC_ST_DONE;
			endcase
		end
	end

	// ==========================================================
	// Switch drive
	always_comb begin
		sw_nxt = '0;
		unique case (mode)
			// (RULE1) manual pattern from slot 0
			CBC_MODE_MANUAL: sw_nxt = pat_r[`CBC_SLOT_MANUAL];
			// (RULE2) timed pattern from slot 0
			CBC_MODE_TIMED:  sw_nxt = pat_r[`CBC_SLOT_MANUAL];
			CBC_MODE_AUTO: begin
				// (RULE3) stepped slot, spent cells masked
				for (int i = 0; i < 12; i++)
					sw_nxt[i] = pat_r[idx_r][i] && val_r[i] != '0;
			end
			CBC_MODE_OFF:    sw_nxt = '0;
		endcase
		// (RULE18) pause during measurement
		if (!balancing_on || st_r != CBC_ST_RUN || (pause && measure_busy))
			sw_nxt = '0;
	end
	assign dec_now = tick && mode == CBC_MODE_AUTO;

	// (RULE7) bit n-1 drives cell n
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			bal_sw <= '0;
		else
			bal_sw <= sw_nxt;
	end
endmodule : cbc_device

// File: src/cbc_host.sv
`timescale 1ns/10ps
`include "cbc_regs.svh"
module cbc_host (
	input  wire logic         ref_clk,  // 100 MHz clock
	input  wire logic         rst_b,    // async reset, low
	cbc_link_if.host          link,     // frames to device
	input  wire logic [3:0]   sw_addr,  // register address
	input  wire logic [15:0]  sw_wdata, // write data
	input  wire logic         sw_wr,    // write strobe
	input  wire logic         sw_rd,    // read strobe
	output logic [15:0]       sw_rdata  // read data, next cycle
);
	import cbc_pkg::*;

	logic [15:0] cmd_r;
	cbc_word_t   wdata_r;
	cbc_word_t   rdata_r;
	logic        got_r;
	logic        go;
	logic [3:0]  dev;
	logic        rw;
	logic [2:0]  page;

	assign dev  = cmd_r[`CBC_H_DEV_LSB +: 4];
	assign rw   = cmd_r[`CBC_H_RW_BIT];
	assign page = cmd_r[`CBC_H_PAGE_LSB +: 3];
	assign go   = sw_wr && sw_addr == `CBC_H_GO;

	// ==========================================================
	// Software registers
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cmd_r   <= '0;
			wdata_r <= '0;
		end else if (sw_wr) begin
			if (sw_addr == `CBC_H_CMD)
				cmd_r <= sw_wdata;
			if (sw_addr == `CBC_H_WDATA)
				wdata_r <= sw_wdata[13:0];
		end
	end

	// A new answer sets the flag even if software clears it that cycle.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			got_r   <= 1'b0;
			rdata_r <= '0;
		end else if (link.rsp_valid) begin
			got_r   <= 1'b1;
			rdata_r <= link.rsp_data;
		end else if (go) begin
			got_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sw_rdata <= '0;
		end else if (sw_rd) begin
			unique case (sw_addr)
				`CBC_H_CMD:    sw_rdata <= cmd_r;
				`CBC_H_WDATA:  sw_rdata <= {2'h0, wdata_r};
				`CBC_H_RDATA:  sw_rdata <= {2'h0, rdata_r};
				`CBC_H_STATUS: sw_rdata <= {15'h0000, got_r};
				default:       sw_rdata <= '0;
			endcase
		end else begin
			sw_rdata <= '0;
		end
	end

	// ==========================================================
	// Frame launch: one cycle, address and check value always sent.
	// (RULE19) software sequences enable last
	// (RULE20) chained address and CRC
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			link.frm_valid <= 1'b0;
			link.frm_rw    <= 1'b0;
			link.frm_page  <= '0;
			link.frm_addr  <= '0;
			link.frm_data  <= '0;
			link.frm_dev   <= '0;
			link.frm_crc   <= '0;
		end else begin
			link.frm_valid <= go;
			if (go) begin
				link.frm_rw   <= rw;
				link.frm_page <= page;
				link.frm_addr <= cmd_r[5:0];
				// (RULE5) command frames carry zero data
				link.frm_data <= (rw == `CBC_RW_WRITE) ? wdata_r : '0;
				link.frm_dev  <= dev;
				link.frm_crc  <= cbc_crc4(dev, rw, page, cmd_r[5:0],
					(rw == `CBC_RW_WRITE) ? wdata_r : '0);
			end
		end
	end
endmodule : cbc_host

// File: src/cbc_link_if.sv
`timescale 1ns/10ps
interface cbc_link_if;
	logic                frm_valid;
	logic                frm_rw;
	logic [2:0]          frm_page;
	logic [5:0]          frm_addr;
	cbc_pkg::cbc_word_t  frm_data;
	logic [3:0]          frm_dev;
	logic [3:0]          frm_crc;
	logic                rsp_valid;
	cbc_pkg::cbc_word_t  rsp_data;

	modport dev (input frm_valid, frm_rw, frm_page, frm_addr, frm_data,
		frm_dev, frm_crc, output rsp_valid, rsp_data);
	modport host (output frm_valid, frm_rw, frm_page, frm_addr, frm_data,
		frm_dev, frm_crc, input rsp_valid, rsp_data);
endinterface : cbc_link_if

// File: src/cbc_pkg.sv
package cbc_pkg;
	typedef enum logic [1:0] {
		CBC_MODE_OFF    = 2'h0,
		CBC_MODE_MANUAL = 2'h1,
		CBC_MODE_TIMED  = 2'h2,
		CBC_MODE_AUTO   = 2'h3
	} cbc_mode_t;

	typedef enum logic [3:0] {
		CBC_ST_IDLE = 4'b0001,
		CBC_ST_RUN  = 4'b0010,
		CBC_ST_WAIT = 4'b0100,
		CBC_ST_DONE = 4'b1000
	} cbc_state_t;

	typedef logic [13:0] cbc_word_t;
	typedef logic [11:0] cbc_cells_t;

	// Four-bit check value over a frame: nibble-wise xor fold.
	function automatic logic [3:0] cbc_crc4(input logic [3:0] dev,
		input logic rw, input logic [2:0] page, input logic [5:0] addr,
		input logic [13:0] data);
		logic [27:0] f;
		f = {dev, rw, page, addr, data};
		return f[3:0] ^ f[7:4] ^ f[11:8] ^ f[15:12] ^ f[19:16] ^
			f[23:20] ^ f[27:24];
	endfunction : cbc_crc4
endpackage : cbc_pkg

// File: src/cbc_regs.svh
`ifndef CBC_REGS_SVH
`define CBC_REGS_SVH
// Overview of operation
// (RULE1) Setup bits 1:0 code 01 is manual
// (RULE2) Code 10 is timed, off after duration
// (RULE3) Code 11 is automatic, stepped patterns
// (RULE4) Setup bit 9 turns selected switches on
// (RULE5) Page 3 address 10h command also enables
// (RULE6) Clearing enable or inhibit command stops balancing
// (RULE7) Pattern bit n-1 drives cell n switch
// (RULE8) Pointer picks pattern slot; slot 0 manual/timed
// (RULE9) Automatic mode steps slots 1, 2, 3 onward
// (RULE10) Empty slot restarts automatic sequence at 1
// (RULE11) Duration code sits in time register 13:7
// (RULE12) Code 3 is one minute, 15 five
// (RULE13) Host sets watchdog above duration, all ones
// (RULE14) Automatic mode waits, switches off, between cycles
// (RULE15) Wait code 100 in bits 4:2 is 8 s
// (RULE16) Host computes and loads per-cell balance values
// (RULE17) 28-bit values in register pairs from 20h
// (RULE18) Pause flag stops balancing during measurements
// (RULE19) Host enables balancing only as last step
// (RULE20) Chained frames carry address and CRC
// (RULE21) Automatic mode drops cells whose value is spent

// ==========================================================
// Frame fields
`define CBC_RW_WRITE      1'b1
`define CBC_RW_CMD        1'b0
`define CBC_PAGE_REG      3'b010
`define CBC_PAGE_CMD      3'b011
`define CBC_CMD_ENABLE    6'h10
`define CBC_CMD_INHIBIT   6'h11
// ==========================================================
// Page 2 register addresses
`define CBC_ADDR_SETUP    6'h13
`define CBC_ADDR_PATTERN  6'h14
`define CBC_ADDR_TIME     6'h15
`define CBC_ADDR_DEVSET   6'h19
`define CBC_ADDR_VAL_LO   6'h20
`define CBC_ADDR_VAL_HI   6'h37
// ==========================================================
// Field positions
`define CBC_MODE_MSB      1
`define CBC_MODE_LSB      0
`define CBC_WAIT_MSB      4
`define CBC_WAIT_LSB      2
`define CBC_PTR_MSB       8
`define CBC_PTR_LSB       5
`define CBC_EN_BIT        9
`define CBC_DUR_MSB       13
`define CBC_DUR_LSB       7
`define CBC_PAUSE_BIT     7
`define CBC_SETUP_RST     14'h0000
`define CBC_TIME_RST      14'h0000
`define CBC_SLOT_MANUAL   4'h0
`define CBC_SLOT_FIRST    4'h1
// ==========================================================
// Timing: one duration step is 20 s, wait is two seconds per code
`define CBC_DUR_STEP_S    20
`define CBC_WAIT_STEP_S   2
`define CBC_CLK_HZ        100000000
// ==========================================================
// Host controller register map
`define CBC_H_CMD         4'h0
`define CBC_H_WDATA       4'h1
`define CBC_H_GO          4'h2
`define CBC_H_RDATA       4'h3
`define CBC_H_STATUS      4'h4
`define CBC_H_DEV_LSB     10
`define CBC_H_RW_BIT      9
`define CBC_H_PAGE_LSB    6
`endif
